// ===== icop_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Host equipment on the communications link
// ----------------------------------------------------------------
module icop_host_model (
  // Clock
  input wire logic clk,
  // Command word link
  output logic cmd_wr,
  output logic [15:0] cmd_wdata
);
  // Link idles with no strobe
  initial begin
    cmd_wr = 1'b0;
    cmd_wdata = 16'h0000;
  end

  // Whole 16-bit word per strobe; caller is at a rising edge
  // Strobe stays up on return so words can go back to back
  task send(input logic [15:0] w);
    cmd_wr <= 1'b1;
    cmd_wdata <= w;
    @(posedge clk);
  endtask : send

  // Released data shows the inverse so a stale word is never trusted
  task idle;
    cmd_wr <= 1'b0;
    cmd_wdata <= ~cmd_wdata;
  endtask : idle
endmodule : icop_host_model

// ===== icop_pkg.sv
package icop_pkg;
  // Output function selector codes
  localparam logic [10:0] SEL_UNIVERSAL = 11'd27;
  localparam logic [10:0] SEL_NEG_OFFSET = 11'd1000;
  localparam logic [10:0] SEL_UNIVERSAL_NEG = 11'd1027;
  // Command word bit positions per terminal
  localparam int BIT_TR_A = 0;
  localparam int BIT_TR_B = 1;
  localparam int BIT_TR_C = 2;
  localparam int BIT_RELAY_A = 4;
  localparam int BIT_ALARM = 8;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // Analog monitor source codes
  localparam logic [7:0] MON_SRC_HOST = 8'h0a;
  localparam logic [7:0] MON_SRC_CAL = 8'h0e;
  localparam logic [15:0] MON_FULL_SCALE = 16'hffff;
  localparam logic [15:0] GAIN_UNITY = 16'd100;
  // PID mode settings
  localparam logic [1:0] PID_OFF = 2'd0;
  localparam logic [1:0] PID_NORMAL = 2'd1;
  localparam logic [1:0] PID_INVERSE = 2'd2;
  localparam logic [1:0] CL_ENABLE = 2'd1;
  localparam logic signed [15:0] FREQ_ZERO = 16'sh0000;
  typedef enum logic [1:0] {
    ICOP_STOP = 2'b00,
    ICOP_FWD = 2'b01,
    ICOP_REV = 2'b11
  } icop_run_t;
endpackage : icop_pkg

// ===== icop_top.sv
`timescale 1ns/1ns
// Operation
// R1: Code 27 drives terminal from command bit
// R2: Code 1027 inverts universal output polarity
// R3: Terminals take states only from host word; code drives them from func_level unless the selector is 27 or 1027
// R4: Bits 0..2 drive transistor outputs a..c
// R5: Bit 4 relay, bit 8 alarm relay
// R6: Monitor source 10 routes host data
// R7: Monitor source 14 forces full scale
// R8: Each monitor scaled by its gain
// R9: Monitor a mode by setting and switch
// R10: Reverse run negates reference frequency
// R11: Stop substitutes zero reference frequency
// R12: Clamp output to high frequency limit
// R13: Overload prevention selects suppression frequency
// R14: Current limit only if level nonzero, enable 1
// R15: DC braking replaces voltage and frequency
// R16: Regeneration redirection holds frequency higher
// R17: PID command only in mode 1 or 2
// R18: PID ignores secondary and auxiliary sources
// R19: Multistep one, two manual only
// R20: Multistep four only for PID command
// R21: Invert PID error on input or mode
// R22: Slow-flow stop forces PID output zero
// R23: Selector plus 1000 inverts terminal logic
// R24: Terminals update one clock after word
// R25: Override priority braking, limit, overload, clamp
module icop_top
  import icop_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host command word from the communications link
  input wire logic cmd_wr,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] host_output_command_word,
  // Output function selectors and internal function signals
  input wire logic [10:0] out_select_transistor_a,
  input wire logic [10:0] out_select_transistor_b,
  input wire logic [10:0] out_select_transistor_c,
  input wire logic [10:0] out_select_relay_a,
  input wire logic [10:0] out_select_alarm_relay,
  input wire logic [4:0] func_level,
  // Output terminals
  output logic transistor_out_a,
  output logic transistor_out_b,
  output logic transistor_out_c,
  output logic relay_out_a,
  output logic alarm_relay_out,
  // Analog monitors
  input wire logic [7:0] monitor_a_source,
  input wire logic [7:0] monitor_b_source,
  input wire logic [15:0] monitor_a_gain,
  input wire logic [15:0] monitor_b_gain,
  input wire logic monitor_a_mode_select,
  input wire logic monitor_a_mode_switch,
  input wire logic [15:0] mon_internal_a,
  input wire logic [15:0] mon_internal_b,
  input wire logic [15:0] mon_host_a,
  input wire logic [15:0] mon_host_b,
  output logic [15:0] analog_monitor_a,
  output logic [15:0] analog_monitor_b,
  output logic monitor_a_current,
  output logic monitor_b_current,
  // Drive command path
  input wire logic run_forward_cmd,
  input wire logic run_reverse_cmd,
  input wire logic signed [15:0] ref_freq,
  input wire logic signed [15:0] accel_freq,
  input wire logic signed [15:0] freq_high_limit,
  input wire logic overload_enable,
  input wire logic signed [15:0] overload_freq,
  input wire logic [15:0] current_limit_level,
  input wire logic [1:0] current_limit_enable,
  input wire logic signed [15:0] current_limit_freq,
  input wire logic dc_brake_active,
  input wire logic signed [15:0] dc_brake_freq,
  input wire logic [15:0] dc_brake_volt,
  input wire logic [15:0] norm_volt,
  input wire logic regen_enable,
  input wire logic signed [15:0] regen_freq,
  output logic signed [15:0] accel_input_freq,
  output logic signed [15:0] out_freq,
  output logic [15:0] out_volt,
  // PID frequency command path
  input wire logic [1:0] pid_mode,
  input wire logic signed [15:0] pid_cmd_src,
  input wire logic signed [15:0] pid_feedback,
  input wire logic multistep_select_four,
  input wire logic signed [15:0] multistep_freq_four,
  input wire logic inverse_action_input,
  input wire logic slow_flow_stop,
  input wire logic [2:0] slow_flow_cond,
  input wire logic signed [15:0] pid_drive_in,
  input wire logic signed [15:0] manual_freq,
  output logic pid_active,
  output logic signed [15:0] pid_error,
  output logic signed [15:0] drive_freq_cmd
);

  // ----------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------
  // Drive level for one terminal: universal, inverted universal,
  // or an internal function with optional negative logic
  function automatic logic term_level(input logic [10:0] sel,
                                      input logic cmd_bit,
                                      input logic func_bit);
    logic lv;
    lv = func_bit;
    if (sel == SEL_UNIVERSAL) begin
      lv = cmd_bit; // [R1]
    end else if (sel == SEL_UNIVERSAL_NEG) begin
      lv = ~cmd_bit; // [R2]
    end else if (sel >= SEL_NEG_OFFSET) begin
      lv = ~func_bit; // [R23]
    end
    return lv;
  endfunction : term_level

  // Monitor value: host data, calibration, or internal, then gain
  function automatic logic [15:0] mon_value(input logic [7:0] src,
                                            input logic [15:0] gain,
                                            input logic [15:0] internal,
                                            input logic [15:0] host);
    logic [15:0] raw;
    logic [31:0] prod;
    raw = internal;
    prod = 32'h0;
    if (src == MON_SRC_CAL) begin
      raw = MON_FULL_SCALE; // [R7]
    end else if (src == MON_SRC_HOST) begin
      raw = host; // [R6]
    end
    prod = (32'(raw) * 32'(gain)) / 32'(GAIN_UNITY); // [R8]
    if (prod > 32'(MON_FULL_SCALE)) begin
      prod = 32'(MON_FULL_SCALE);
    end
    return prod[15:0];
  endfunction : mon_value

  // ----------------------------------------------------------
  // Host command word register
  // ----------------------------------------------------------
  logic [15:0] cmd_r, cmd_nxt;

  // Only the host link may change terminal command bits
  always_comb begin
    cmd_nxt = cmd_r;
    if (cmd_wr) begin
      cmd_nxt = cmd_wdata; // [R3]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd_r <= CMD_RESET;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  assign host_output_command_word = cmd_r;

  // ----------------------------------------------------------
  // Output terminals
  // ----------------------------------------------------------
  logic [4:0] term_r, term_nxt;

  // Unused command bits (3, 5-7, 9-15) reach no terminal
  always_comb begin
    term_nxt[0] = term_level(out_select_transistor_a,
                             cmd_nxt[BIT_TR_A], func_level[0]); // [R4]
    term_nxt[1] = term_level(out_select_transistor_b,
                             cmd_nxt[BIT_TR_B], func_level[1]); // [R4]
    term_nxt[2] = term_level(out_select_transistor_c,
                             cmd_nxt[BIT_TR_C], func_level[2]); // [R4]
    term_nxt[3] = term_level(out_select_relay_a,
                             cmd_nxt[BIT_RELAY_A], func_level[3]); // [R5]
    term_nxt[4] = term_level(out_select_alarm_relay,
                             cmd_nxt[BIT_ALARM], func_level[4]); // [R5]
  end

  // Registered so terminals change one clock after the write
  always_ff @(posedge clk) begin
    if (!rstn) begin
      term_r <= '0;
    end else begin
      term_r <= term_nxt; // [R24]
    end
  end

  assign transistor_out_a = term_r[0];
  assign transistor_out_b = term_r[1];
  assign transistor_out_c = term_r[2];
  assign relay_out_a = term_r[3];
  assign alarm_relay_out = term_r[4];

  // ----------------------------------------------------------
  // Analog monitors and drive command path
  // ----------------------------------------------------------
  logic [15:0] mon_a_r, mon_a_nxt, mon_b_r, mon_b_nxt;
  logic mode_a_r, mode_a_nxt;
  logic signed [15:0] acc_in_r, acc_in_nxt, ofreq_r, ofreq_nxt;
  logic [15:0] ovolt_r, ovolt_nxt;
  logic cl_on;

  always_comb begin
    mon_a_nxt = mon_value(monitor_a_source, monitor_a_gain,
                          mon_internal_a, mon_host_a);
    mon_b_nxt = mon_value(monitor_b_source, monitor_b_gain,
                          mon_internal_b, mon_host_b);
    // Current mode needs both the setting and the switch
    mode_a_nxt = monitor_a_mode_select & monitor_a_mode_switch; // [R9]
  end

  // Reference conditioning and overrides, lowest priority first
  always_comb begin
    cl_on = (current_limit_level != 16'h0) &&
            (current_limit_enable == CL_ENABLE); // [R14]
    if (run_reverse_cmd && !run_forward_cmd) begin
      acc_in_nxt = -ref_freq; // [R10]
    end else if (run_forward_cmd && !run_reverse_cmd) begin
      acc_in_nxt = ref_freq;
    end else begin
      acc_in_nxt = FREQ_ZERO; // [R11]
    end
    ofreq_nxt = accel_freq;
    if (regen_enable && (regen_freq > ofreq_nxt)) begin
      ofreq_nxt = regen_freq; // [R16]
    end
    if (ofreq_nxt > freq_high_limit) begin
      ofreq_nxt = freq_high_limit; // [R12] [R25]
    end
    if (overload_enable) begin
      ofreq_nxt = overload_freq; // [R13] [R25]
    end
    if (cl_on) begin
      ofreq_nxt = current_limit_freq; // [R14] [R25]
    end
    ovolt_nxt = norm_volt;
    if (dc_brake_active) begin
      ofreq_nxt = dc_brake_freq; // [R15] [R25]
      ovolt_nxt = dc_brake_volt; // [R15]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mon_a_r <= '0;
      mon_b_r <= '0;
      mode_a_r <= 1'b0;
      acc_in_r <= FREQ_ZERO;
      ofreq_r <= FREQ_ZERO;
      ovolt_r <= '0;
    end else begin
      mon_a_r <= mon_a_nxt;
      mon_b_r <= mon_b_nxt;
      mode_a_r <= mode_a_nxt;
      acc_in_r <= acc_in_nxt;
      ofreq_r <= ofreq_nxt;
      ovolt_r <= ovolt_nxt;
    end
  end

  assign analog_monitor_a = mon_a_r;
  assign analog_monitor_b = mon_b_r;
  assign monitor_a_current = mode_a_r;
  assign monitor_b_current = 1'b1; // [R9] always current mode
  assign accel_input_freq = acc_in_r;
  assign out_freq = ofreq_r;
  assign out_volt = ovolt_r;

  // ----------------------------------------------------------
  // PID frequency command generator
  // ----------------------------------------------------------
  logic pid_on;
  logic signed [15:0] pcmd, perr_nxt, perr_r, dfc_nxt, dfc_r;

  // Secondary and auxiliary sources have no path here under PID;
  // multistep one and two are already folded into manual_freq
  always_comb begin
    pid_on = (pid_mode == PID_NORMAL) ||
             (pid_mode == PID_INVERSE); // [R17]
    pcmd = multistep_select_four ? multistep_freq_four
                                 : pid_cmd_src; // [R20]
    perr_nxt = pcmd - pid_feedback;
    if (inverse_action_input ^ (pid_mode == PID_INVERSE)) begin
      perr_nxt = -perr_nxt; // [R21]
    end
    dfc_nxt = manual_freq; // [R19]
    if (pid_on) begin
      dfc_nxt = pid_drive_in; // [R17] [R18]
      if (slow_flow_stop && (slow_flow_cond != 3'b000)) begin
        dfc_nxt = FREQ_ZERO; // [R22]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      perr_r <= FREQ_ZERO;
      dfc_r <= FREQ_ZERO;
    end else begin
      perr_r <= perr_nxt;
      dfc_r <= dfc_nxt;
    end
  end

  assign pid_active = pid_on;
  assign pid_error = perr_r;
  assign drive_freq_cmd = dfc_r;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  sequence s_write;
    cmd_wr && out_select_transistor_a == SEL_UNIVERSAL;
  endsequence

  property p_univ;
    @(posedge clk) disable iff (!rstn)
      s_write |=> transistor_out_a == $past(cmd_wdata[BIT_TR_A]);
  endproperty
  a_univ: assert property (p_univ) // [R1]
    else $error("universal output mismatch");

  property p_univ_neg;
    @(posedge clk) disable iff (!rstn)
      (cmd_wr && out_select_alarm_relay == SEL_UNIVERSAL_NEG) |=>
        alarm_relay_out == !$past(cmd_wdata[BIT_ALARM]);
  endproperty
  a_univ_neg: assert property (p_univ_neg) // [R2]
    else $error("negative universal output mismatch");

  property p_hold;
    @(posedge clk) disable iff (!rstn)
      (!cmd_wr && $stable(out_select_relay_a) &&
       out_select_relay_a == SEL_UNIVERSAL) ##1
      (!cmd_wr && $stable(out_select_relay_a))
        |=> $stable(relay_out_a);
  endproperty
  a_hold: assert property (p_hold) // [R24]
    else $error("relay output changed without a write");

  property p_cal;
    @(posedge clk) disable iff (!rstn)
      (monitor_b_source == MON_SRC_CAL && monitor_b_gain == GAIN_UNITY)
        |=> analog_monitor_b == MON_FULL_SCALE;
  endproperty
  a_cal: assert property (p_cal) // [R7]
    else $error("calibration output not full scale");

  property p_stop;
    @(posedge clk) disable iff (!rstn)
      (!run_forward_cmd && !run_reverse_cmd) |=>
        accel_input_freq == FREQ_ZERO;
  endproperty
  a_stop: assert property (p_stop) // [R11]
    else $error("stop did not zero the reference");

  property p_rev;
    @(posedge clk) disable iff (!rstn)
      (run_reverse_cmd && !run_forward_cmd) |=>
        accel_input_freq == -$past(ref_freq);
  endproperty
  a_rev: assert property (p_rev) // [R10]
    else $error("reverse did not negate the reference");

  property p_brake;
    @(posedge clk) disable iff (!rstn)
      dc_brake_active |=> out_freq == $past(dc_brake_freq) &&
                          out_volt == $past(dc_brake_volt);
  endproperty
  a_brake: assert property (p_brake) // [R15]
    else $error("braking values not applied");

  property p_clamp;
    @(posedge clk) disable iff (!rstn)
      (!dc_brake_active && !cl_on && !overload_enable) |=>
        out_freq <= $past(freq_high_limit);
  endproperty
  a_clamp: assert property (p_clamp) // [R12]
    else $error("output above high limit");

  property p_slow;
    @(posedge clk) disable iff (!rstn)
      (pid_on && slow_flow_stop && slow_flow_cond != 3'b000) |=>
        drive_freq_cmd == FREQ_ZERO;
  endproperty
  a_slow: assert property (p_slow) // [R22]
    else $error("slow flow stop not zero");

  property p_pid_off;
    @(posedge clk) disable iff (!rstn)
      (pid_mode == PID_OFF) |=> drive_freq_cmd == $past(manual_freq);
  endproperty
  a_pid_off: assert property (p_pid_off) // [R17]
    else $error("PID path used while disabled");

endmodule : icop_top

// ===== icop_top_tb_top.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Testbench for the command and output path
// ----------------------------------------------------------------
module icop_top_tb_top
  import icop_pkg::*;
;
  logic clk, rstn, cmd_wr, monitor_a_mode_select, monitor_a_mode_switch;
  logic run_forward_cmd, run_reverse_cmd, overload_enable, dc_brake_active;
  logic regen_enable, multistep_select_four, inverse_action_input;
  logic slow_flow_stop, transistor_out_a, transistor_out_b;
  logic transistor_out_c, relay_out_a, alarm_relay_out;
  logic monitor_a_current, monitor_b_current, pid_active;
  logic [1:0] current_limit_enable, pid_mode;
  logic [2:0] slow_flow_cond;
  logic [4:0] func_level;
  logic [7:0] monitor_a_source, monitor_b_source;
  logic [10:0] out_select_transistor_a, out_select_transistor_b;
  logic [10:0] out_select_transistor_c, out_select_relay_a;
  logic [10:0] out_select_alarm_relay;
  logic [15:0] cmd_wdata, host_output_command_word, monitor_a_gain;
  logic [15:0] monitor_b_gain, mon_internal_a, mon_internal_b, mon_host_a;
  logic [15:0] mon_host_b, analog_monitor_a, analog_monitor_b;
  logic [15:0] current_limit_level, dc_brake_volt, norm_volt, out_volt;
  logic signed [15:0] ref_freq, accel_freq, freq_high_limit, overload_freq;
  logic signed [15:0] current_limit_freq, dc_brake_freq, regen_freq;
  logic signed [15:0] accel_input_freq, out_freq, pid_cmd_src, pid_feedback;
  logic signed [15:0] multistep_freq_four, pid_drive_in, manual_freq;
  logic signed [15:0] pid_error, drive_freq_cmd;
  int err_count, tests_run;

  // ----------------------------------------------------------------
  // Design, host model and clock
  // ----------------------------------------------------------------
  icop_top icop_top_inst (.clk, .rstn, .cmd_wr, .cmd_wdata,
    .host_output_command_word, .out_select_transistor_a,
    .out_select_transistor_b, .out_select_transistor_c, .out_select_relay_a,
    .out_select_alarm_relay, .func_level, .transistor_out_a,
    .transistor_out_b, .transistor_out_c, .relay_out_a, .alarm_relay_out,
    .monitor_a_source, .monitor_b_source, .monitor_a_gain, .monitor_b_gain,
    .monitor_a_mode_select, .monitor_a_mode_switch, .mon_internal_a,
    .mon_internal_b, .mon_host_a, .mon_host_b, .analog_monitor_a,
    .analog_monitor_b, .monitor_a_current, .monitor_b_current,
    .run_forward_cmd, .run_reverse_cmd, .ref_freq, .accel_freq,
    .freq_high_limit, .overload_enable, .overload_freq,
    .current_limit_level, .current_limit_enable, .current_limit_freq,
    .dc_brake_active, .dc_brake_freq, .dc_brake_volt, .norm_volt,
    .regen_enable, .regen_freq, .accel_input_freq, .out_freq, .out_volt,
    .pid_mode, .pid_cmd_src, .pid_feedback, .multistep_select_four,
    .multistep_freq_four, .inverse_action_input, .slow_flow_stop,
    .slow_flow_cond, .pid_drive_in, .manual_freq, .pid_active, .pid_error,
    .drive_freq_cmd);
  icop_host_model icop_host_model_inst (.clk(clk), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata));

  // 125 MHz clock
  always #4 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task give_verdict;
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // Inputs land at one edge, registered outputs are read a cycle later
  task settle;
    @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Terminal order alarm, relay, c, b, a
  task automatic term(input logic [4:0] e);
    chk("terminals", {11'h0, e}, {11'h0, alarm_relay_out, relay_out_a,
      transistor_out_c, transistor_out_b, transistor_out_a});
  endtask : term

  task automatic sel_all(input logic [10:0] v);
    out_select_transistor_a <= v;
    out_select_transistor_b <= v;
    out_select_transistor_c <= v;
    out_select_relay_a <= v;
    out_select_alarm_relay <= v;
  endtask : sel_all

  // One word, then release; outputs read after the taking edge
  task automatic write_word(input logic [15:0] w);
    @(posedge clk);
    icop_host_model_inst.send(w);
    icop_host_model_inst.idle();
    @(negedge clk);
  endtask : write_word

  task automatic drv(input logic dc, input logic [15:0] cll,
    input logic [1:0] cle, input logic ov, rg,
    input logic signed [15:0] acc, e);
    @(posedge clk);
    dc_brake_active <= dc;
    current_limit_level <= cll;
    current_limit_enable <= cle;
    overload_enable <= ov;
    regen_enable <= rg;
    accel_freq <= acc;
    settle;
    chk("out_freq", e, out_freq);
    chk("out_volt", dc ? 16'h0321 : 16'h0456, out_volt);
  endtask : drv

  task automatic run(input logic f, r, input logic signed [15:0] e);
    @(posedge clk);
    run_forward_cmd <= f;
    run_reverse_cmd <= r;
    settle;
    chk("accel_input_freq", e, accel_input_freq);
  endtask : run

  task automatic mon(input logic [7:0] sa, sb, input logic [15:0] ga, gb,
    ea, eb);
    @(posedge clk);
    monitor_a_source <= sa;
    monitor_b_source <= sb;
    monitor_a_gain <= ga;
    monitor_b_gain <= gb;
    settle;
    chk("analog_monitor_a", ea, analog_monitor_a);
    chk("analog_monitor_b", eb, analog_monitor_b);
  endtask : mon

  task automatic pid(input logic [1:0] m, input logic inverse_action_cmd, ms, sfs,
    input logic [2:0] cnd, input logic act,
    input logic signed [15:0] eerr, edrv);
    @(posedge clk);
    pid_mode <= m;
    inverse_action_input <= inverse_action_cmd;
    multistep_select_four <= ms;
    slow_flow_stop <= sfs;
    slow_flow_cond <= cnd;
    settle;
    chk("pid_active", {15'h0, act}, {15'h0, pid_active});
    if (act) chk("pid_error", eerr, pid_error);
    chk("drive_freq_cmd", edrv, drive_freq_cmd);
  endtask : pid

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0; rstn = 1'b0; func_level = 5'h00; err_count = 0;
    tests_run = 0; out_select_transistor_a = 11'h000;
    out_select_transistor_b = 11'h000; out_select_transistor_c = 11'h000;
    out_select_relay_a = 11'h000; out_select_alarm_relay = 11'h000;
    monitor_a_source = 8'h00; monitor_b_source = 8'h00;
    monitor_a_gain = 16'h0064; monitor_b_gain = 16'h0064;
    monitor_a_mode_select = 1'b0; monitor_a_mode_switch = 1'b0;
    mon_internal_a = 16'h1234; mon_internal_b = 16'h2222;
    mon_host_a = 16'h0777; mon_host_b = 16'h9000;
    run_forward_cmd = 1'b0; run_reverse_cmd = 1'b0; ref_freq = 16'sd1500;
    accel_freq = 16'sd200; freq_high_limit = 16'sd1000;
    overload_enable = 1'b0; overload_freq = 16'sd400;
    current_limit_level = 16'h0000; current_limit_enable = 2'd0;
    current_limit_freq = 16'sd500; dc_brake_active = 1'b0;
    dc_brake_freq = 16'sd50; dc_brake_volt = 16'h0321;
    norm_volt = 16'h0456; regen_enable = 1'b0; regen_freq = 16'sd300;
    pid_mode = 2'd0; pid_cmd_src = 16'sd500; pid_feedback = 16'sd200;
    multistep_select_four = 1'b0; multistep_freq_four = 16'sd800;
    inverse_action_input = 1'b0; slow_flow_stop = 1'b0;
    slow_flow_cond = 3'h0; pid_drive_in = 16'sd1234; manual_freq = 16'sd77;
    repeat (10) @(posedge clk);
    @(negedge clk);
    term(5'h00);
    chk("readback", 16'h0000, host_output_command_word);
    chk("monitor_b_current", 16'h0001, {15'h0, monitor_b_current});
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // Universal output: all five terminals follow the word
    @(posedge clk);
    sel_all(SEL_UNIVERSAL);
    func_level <= 5'h15;
    icop_host_model_inst.send(16'h0117);
    icop_host_model_inst.idle();
    @(negedge clk);
    term(5'h1f);
    chk("readback", 16'h0117, host_output_command_word);
    write_word(16'hfee8);
    term(5'h00);
    // Back-to-back words: the last one stands
    @(posedge clk);
    icop_host_model_inst.send(16'h0100);
    icop_host_model_inst.send(16'h0011);
    icop_host_model_inst.idle();
    @(negedge clk);
    term(5'h09);
    chk("readback", 16'h0011, host_output_command_word);
    settle;
    term(5'h09);
    // Negative logic universal output
    @(posedge clk);
    sel_all(SEL_UNIVERSAL_NEG);
    settle;
    write_word(16'h0115);
    term(5'h02);
    // Other functions: plain and offset by one thousand
    @(posedge clk);
    sel_all(11'd5);
    settle;
    term(5'h15);
    @(posedge clk);
    sel_all(11'd1005);
    settle;
    term(5'h0a);
    // Analog monitors
    mon(MON_SRC_HOST, MON_SRC_HOST, 16'd100, 16'd100, 16'h0777,
      16'h9000);
    mon(MON_SRC_CAL, MON_SRC_CAL, 16'd100, 16'd100, MON_FULL_SCALE,
      MON_FULL_SCALE);
    mon(8'h01, MON_SRC_HOST, 16'd50, 16'd200, 16'h091a, 16'hffff);
    mon(8'h01, 8'h01, 16'd100, 16'd100, 16'h1234, 16'h2222);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      monitor_a_mode_select <= i[0];
      monitor_a_mode_switch <= i[1];
      settle;
      chk("monitor_a_current", {15'h0, i == 3},
        {15'h0, monitor_a_current});
      chk("monitor_b_current", 16'h0001, {15'h0, monitor_b_current});
    end
    // Run direction on the reference
    run(1'b1, 1'b0, 16'sd1500);
    run(1'b0, 1'b1, -16'sd1500);
    run(1'b1, 1'b1, 16'sd0);
    run(1'b0, 1'b0, 16'sd0);
    // Frequency overrides in priority order
    drv(1'b1, 16'd7, 2'd1, 1'b1, 1'b0, 16'sd200, 16'sd50);
    drv(1'b0, 16'd7, 2'd1, 1'b1, 1'b0, 16'sd200, 16'sd500);
    drv(1'b0, 16'd7, 2'd2, 1'b1, 1'b0, 16'sd200, 16'sd400);
    drv(1'b0, 16'd0, 2'd1, 1'b1, 1'b0, 16'sd200, 16'sd400);
    drv(1'b0, 16'd0, 2'd1, 1'b0, 1'b0, 16'sd1200, 16'sd1000);
    drv(1'b0, 16'd0, 2'd1, 1'b0, 1'b0, 16'sd1000, 16'sd1000);
    drv(1'b0, 16'd0, 2'd1, 1'b0, 1'b0, 16'sd200, 16'sd200);
    drv(1'b0, 16'd0, 2'd1, 1'b0, 1'b1, 16'sd100, 16'sd300);
    // PID command generator
    pid(2'd0, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 16'sd0, 16'sd77);
    pid(2'd3, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 16'sd0, 16'sd77);
    pid(2'd1, 1'b0, 1'b0, 1'b0, 3'h0, 1'b1, 16'sd300, 16'sd1234);
    pid(2'd1, 1'b1, 1'b0, 1'b0, 3'h0, 1'b1, -16'sd300, 16'sd1234);
    pid(2'd2, 1'b0, 1'b0, 1'b0, 3'h0, 1'b1, -16'sd300, 16'sd1234);
    pid(2'd2, 1'b1, 1'b0, 1'b0, 3'h0, 1'b1, 16'sd300, 16'sd1234);
    pid(2'd1, 1'b0, 1'b1, 1'b0, 3'h0, 1'b1, 16'sd600, 16'sd1234);
    pid(2'd1, 1'b0, 1'b0, 1'b1, 3'h2, 1'b1, 16'sd300, 16'sd0);
    pid(2'd1, 1'b0, 1'b0, 1'b1, 3'h0, 1'b1, 16'sd300, 16'sd1234);
    give_verdict;
  end

  // Watchdog well beyond the fewer than a hundred cycles the tests need
  initial begin
    #20000;
    err_count++;
    give_verdict;
  end
endmodule : icop_top_tb_top
